// [cmp_pkg.sv]
package cmp_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] ctrl_a1_off   = 8'h00;  // compare_control_a, comparator 1
  localparam logic [7:0] insel1_off    = 8'h04;  // compare_input_select, comparator 1
  localparam logic [7:0] ctrl_a2_off   = 8'h08;  // compare_control_a, comparator 2
  localparam logic [7:0] insel2_off    = 8'h0c;  // compare_input_select, comparator 2
  localparam logic [7:0] mirror_off    = 8'h10;  // compare_result_mirror
  localparam logic [7:0] status_off    = 8'h14;  // event flags, write 1 to clear
  localparam logic [7:0] irqen_off     = 8'h18;  // event irq enables, sleep, shutdown enables
  localparam logic [7:0] port_off      = 8'h1c;  // port read with analogue masking
  localparam logic [7:0] ansel_off     = 8'h20;  // analogue select per port pin

  // control_a field positions
  localparam int enable_bit  = 7;
  localparam int result_bit  = 6;
  localparam int invert_bit  = 4;
  localparam int speed_bit   = 2;
  localparam int hyst_bit    = 1;
  localparam int sync_bit    = 0;
  // input select field positions
  localparam int rise_bit    = 7;
  localparam int fall_bit    = 6;
  localparam int pos_lsb     = 3;
  localparam int neg_lsb     = 0;
  // irq enable register field positions
  localparam int sleep_bit   = 4;
  localparam int sd_lsb      = 2;

  // writable masks: unimplemented bits are dropped on write
  localparam logic [7:0] ctrl_a_wmask = 8'h97;
  localparam logic [7:0] ctrl_a_reset = 8'h04;  // speed/power select resets to 1
  localparam logic [7:0] insel_reset  = 8'h00;

  // positive input routing codes
  localparam logic [2:0] pos_gnd  = 3'h7;
  localparam logic [2:0] pos_fvr  = 3'h6;
  localparam logic [2:0] pos_dac  = 3'h5;
  localparam logic [2:0] pos_pin0 = 3'h0;
  // negative input routing codes
  localparam logic [2:0] neg_gnd  = 3'h7;
  localparam logic [2:0] neg_fvr  = 3'h6;
  localparam logic [2:0] neg_pin3 = 3'h3;

  // one-hot analogue connection vectors
  typedef struct packed {
    logic gnd;
    logic fixed_reference;
    logic dac;
    logic positive_pin_0;
  } pos_route_t;

  typedef struct packed {
    logic       gnd;
    logic       fixed_reference;
    logic [3:0] negative_pin;
  } neg_route_t;

  // analogue front-end controls for one comparator
  typedef struct packed {
    pos_route_t pos;
    neg_route_t neg;
    logic       power_on;
    logic       hysteresis_enable;
    logic       speed_power_select;
  } analog_ctrl_t;

  // gate timer clock source kinds
  typedef enum logic [1:0] {
    tclk_sys     = 2'h0,
    tclk_instr   = 2'h1,
    tclk_ext     = 2'h2
  } tclk_src_t;

  // apb slave answer states
  typedef enum logic [1:0] {
    bus_idle   = 2'b01,
    bus_access = 2'b10
  } bus_state_t;

endpackage : cmp_pkg

// [comparator_control_logic.sv]
`timescale 1ns/1ps

// Contract
// - positive select decodes ground, reference, dac, pin0
// - negative select decodes ground, reference, pins 0-3
// - enable clear disconnects every comparator input
// - result is comparison, inverted when polarity set
// - rise enable sets event flag on rising result
// - fall enable sets event flag on falling result
// - sync mode updates output on timer falling edge
// - async mode passes result straight through
// - mirror register bits 1:0 hold both results
// - speed/power bit resets to one, never zero
// - hysteresis bit drives analogue hysteresis enable
// - enable clear powers the comparator down
// - active result with shutdown enable suspends waveform
// - sleep stops sync path on system-clocked timer
// - enabled event wakes device from sleep
// - port read returns zero on analogue pins
// - unimplemented bits read zero, writes ignored
// - flag clear loses to simultaneous new edge
// - result latched once per instruction cycle
// - polarity or enable toggles can set flag
module comparator_control_logic
  import cmp_pkg::*;
#(
  parameter int n_cmp      = 2,  // comparators in the block
  parameter int port_width = 8,  // pins on the readable port
  parameter int instr_div  = 4   // system clocks per instruction cycle
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // analogue side
  input  wire logic [n_cmp-1:0]        raw_compare,
  output analog_ctrl_t [n_cmp-1:0]     analog_ctrl,
  // gate timer
  input  wire logic                    timer_clk_in,
  input  wire tclk_src_t               timer_clk_src,
  output logic [n_cmp-1:0]             timer_gate_result,
  output logic [n_cmp-1:0]             result_pin,
  // waveform unit shutdown and sleep
  output logic                         waveform_shutdown,
  input  wire logic                    sleep_req,
  output logic                         wake_request,
  // digital port
  input  wire logic [port_width-1:0]   port_pins
);

  // per-comparator software state
  logic [n_cmp-1:0][7:0]       ctrl_a_q;      // enable, invert, speed, hyst, sync
  logic [n_cmp-1:0][7:0]       insel_q;       // edge enables and input selects
  logic [n_cmp-1:0]            event_flag_q;  // sticky event flags
  logic [n_cmp-1:0]            irq_en_q;      // per-comparator wake enables
  logic [n_cmp-1:0]            sd_en_q;       // shutdown source enables
  logic                        sleep_q;       // device in sleep
  logic [port_width-1:0]       ansel_q;       // pin is analogue

  // synchronisers
  logic [n_cmp-1:0]            raw_s1_q;      // first flop only feeds second
  logic [n_cmp-1:0]            raw_s2_q;
  logic                        tclk_s1_q;
  logic                        tclk_s2_q;
  logic                        tclk_prev_q;   // for falling edge detection
  logic [port_width-1:0]       port_s1_q;
  logic [port_width-1:0]       port_s2_q;

  // results
  logic [n_cmp-1:0]            result_q;      // latched per instruction cycle
  logic [n_cmp-1:0]            result_prev_q; // for edge detection
  logic [n_cmp-1:0]            live_result;   // unlatched polarity-applied result
  logic [n_cmp-1:0]            sync_result_q; // timer-synchronised copy
  logic [n_cmp-1:0]            rise_evt;
  logic [n_cmp-1:0]            fall_evt;
  logic [n_cmp-1:0]            flag_set;
  logic [n_cmp-1:0]            flag_clr;

  // instruction-cycle enable divider
  logic [$clog2(instr_div)-1:0] div_q;
  logic                        instr_tick;

  // bus
  bus_state_t                  bus_q;
  logic                        wr_en;
  logic                        rd_en;
  logic                        addr_ok;
  logic [7:0]                  rd_byte;
  logic                        tfall;

  // positive routing decode, all off while disabled
  function automatic pos_route_t pos_decode(input logic [2:0] code, input logic en);
    pos_route_t r;
    r = '0;
    if (en) begin
      case (code)
        pos_gnd:  r.gnd             = 1'b1;
        pos_fvr:  r.fixed_reference = 1'b1;
        pos_dac:  r.dac             = 1'b1;
        pos_pin0: r.positive_pin_0  = 1'b1;
        default:  r                 = '0;  // node left floating
      endcase
    end
    return r;
  endfunction : pos_decode

  // negative routing decode, all off while disabled
  function automatic neg_route_t neg_decode(input logic [2:0] code, input logic en);
    neg_route_t r;
    r = '0;
    if (en) begin
      case (code)
        neg_gnd: r.gnd             = 1'b1;
        neg_fvr: r.fixed_reference = 1'b1;
        default: begin
          if (code <= neg_pin3) begin
            r.negative_pin = 4'h1 << code[1:0];
          end
        end
      endcase
    end
    return r;
  endfunction : neg_decode

  // analogue controls per comparator
  always_comb begin
    for (int i = 0; i < n_cmp; i++) begin
      analog_ctrl[i].pos                = pos_decode(insel_q[i][pos_lsb+:3], ctrl_a_q[i][enable_bit]);
      analog_ctrl[i].neg                = neg_decode(insel_q[i][neg_lsb+:3], ctrl_a_q[i][enable_bit]);
      analog_ctrl[i].power_on           = ctrl_a_q[i][enable_bit];
      analog_ctrl[i].hysteresis_enable  = ctrl_a_q[i][hyst_bit];
      analog_ctrl[i].speed_power_select = ctrl_a_q[i][speed_bit];
    end
  end

  // two-flop synchronisers for analogue results, timer clock and port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_s1_q  <= '0;
      raw_s2_q  <= '0;
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      port_s1_q <= '0;
      port_s2_q <= '0;
    end else begin
      raw_s1_q  <= raw_compare;
      raw_s2_q  <= raw_s1_q;
      tclk_s1_q <= timer_clk_in;
      tclk_s2_q <= tclk_s1_q;
      port_s1_q <= port_pins;
      port_s2_q <= port_s1_q;
    end
  end

  // disabled comparator reads low before polarity, so toggles still show
  always_comb begin
    for (int i = 0; i < n_cmp; i++) begin
      live_result[i] = (raw_s2_q[i] & ctrl_a_q[i][enable_bit]) ^ ctrl_a_q[i][invert_bit];
    end
  end

  // instruction-cycle divider
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else if (instr_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign instr_tick = (div_q == ($clog2(instr_div))'(instr_div - 1));

  // result latch, once per instruction cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_q      <= '0;
      result_prev_q <= '0;
    end else if (instr_tick) begin
      result_q      <= live_result;
      result_prev_q <= result_q;
    end
  end

  // edge detectors qualified by the rise and fall enables
  always_comb begin
    for (int i = 0; i < n_cmp; i++) begin
      rise_evt[i] = result_q[i] & ~result_prev_q[i] & insel_q[i][rise_bit];
      fall_evt[i] = ~result_q[i] & result_prev_q[i] & insel_q[i][fall_bit];
    end
  end
  // only count an edge in the tick after the latch moved
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tclk_prev_q <= 1'b0;
    end else begin
      tclk_prev_q <= tclk_s2_q;
    end
  end
  logic edge_tick_q;  // one cycle after each latch update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edge_tick_q <= 1'b0;
    end else begin
      edge_tick_q <= instr_tick;
    end
  end
  assign flag_set = (rise_evt | fall_evt) & {n_cmp{edge_tick_q}};

  // timer falling edge; system-clocked timer sources stop in sleep
  assign tfall = (timer_clk_src == tclk_ext) ? (tclk_prev_q & ~tclk_s2_q)
                                             : (~sleep_q & instr_tick);

  // synchronised copy updates on timer falling edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_result_q <= '0;
    end else if (tfall) begin
      sync_result_q <= result_q;
    end
  end

  // output to timer gate and pin, sync or pass-through
  always_comb begin
    for (int i = 0; i < n_cmp; i++) begin
      timer_gate_result[i] = ctrl_a_q[i][sync_bit] ? sync_result_q[i] : live_result[i];
    end
  end
  assign result_pin = timer_gate_result;

  // shutdown is combinational so it acts at once
  assign waveform_shutdown = |(live_result & sd_en_q);

  // wake from sleep on an enabled flag
  assign wake_request = sleep_q & |(event_flag_q & irq_en_q);

  // apb decode
  assign addr_ok = (paddr == ctrl_a1_off) || (paddr == insel1_off) || (paddr == ctrl_a2_off) ||
                   (paddr == insel2_off)  || (paddr == mirror_off) || (paddr == status_off)  ||
                   (paddr == irqen_off)   || (paddr == port_off)   || (paddr == ansel_off);
  assign wr_en   = psel & penable & pwrite & (bus_q == bus_access);
  assign rd_en   = psel & penable & ~pwrite & (bus_q == bus_access);

  // no wait states: setup, then a single access cycle answered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_q <= bus_idle;
    end else begin
      case (bus_q)
        bus_idle:   bus_q <= (psel & ~penable) ? bus_access : bus_idle;
        bus_access: bus_q <= bus_idle;
        default:    bus_q <= bus_idle;
      endcase
    end
  end
  assign pready  = (bus_q == bus_access);
  assign pslverr = pready & ~addr_ok;

  // control register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < n_cmp; i++) begin
        ctrl_a_q[i] <= ctrl_a_reset;
        insel_q[i]  <= insel_reset;
      end
    end else if (wr_en) begin
      case (paddr)
        ctrl_a1_off: ctrl_a_q[0] <= (pwdata[7:0] & ctrl_a_wmask) | ctrl_a_reset;
        insel1_off:  insel_q[0]  <= pwdata[7:0];
        ctrl_a2_off: ctrl_a_q[1] <= (pwdata[7:0] & ctrl_a_wmask) | ctrl_a_reset;
        insel2_off:  insel_q[1]  <= pwdata[7:0];
        default:     ;  // other offsets handled elsewhere
      endcase
    end
  end

  // enables, sleep and analogue pin selection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= '0;
      sd_en_q  <= '0;
      sleep_q  <= 1'b0;
      ansel_q  <= '0;
    end else begin
      if (wr_en && paddr == irqen_off) begin
        irq_en_q <= pwdata[n_cmp-1:0];
        sd_en_q  <= pwdata[sd_lsb+:n_cmp];
      end
      if (wr_en && paddr == ansel_off) begin
        ansel_q <= pwdata[port_width-1:0];
      end
      // sleep is entered by software or host request, left only by wake
      if (wr_en && paddr == irqen_off && pwdata[sleep_bit]) begin
        sleep_q <= 1'b1;
      end else if (sleep_req) begin
        sleep_q <= 1'b1;
      end else if (wake_request) begin
        sleep_q <= 1'b0;
      end
    end
  end

  // sticky flags, write 1 to clear; a new edge wins over the clear
  assign flag_clr = (wr_en && paddr == status_off) ? pwdata[n_cmp-1:0] : '0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      event_flag_q <= '0;
    end else begin
      event_flag_q <= (event_flag_q & ~flag_clr) | flag_set;
    end
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;  // unmapped and unimplemented read zero
    case (paddr)
      ctrl_a1_off: rd_byte = (ctrl_a_q[0] & ctrl_a_wmask) | (8'(result_q[0]) << result_bit);
      insel1_off:  rd_byte = insel_q[0];
      ctrl_a2_off: rd_byte = (ctrl_a_q[1] & ctrl_a_wmask) | (8'(result_q[1]) << result_bit);
      insel2_off:  rd_byte = insel_q[1];
      mirror_off:  rd_byte = 8'(result_q);
      status_off:  rd_byte = 8'(event_flag_q);
      irqen_off:   rd_byte = 8'(irq_en_q) | (8'(sd_en_q) << sd_lsb) | (8'(sleep_q) << sleep_bit);
      port_off:    rd_byte = 8'(port_s2_q & ~ansel_q);
      ansel_off:   rd_byte = 8'(ansel_q);
      default:     rd_byte = 8'h00;
    endcase
  end

  // registered read data, captured at the access edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

endmodule : comparator_control_logic

// [cmp_partner.sv]
`timescale 1ns/1ps

// far side: the analogue comparison reduced to one raw bit per comparator
module cmp_partner
  import cmp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire analog_ctrl_t [1:0] analog_ctrl,
  input  wire logic [1:0]         vp_above,     // bench-chosen: node + above node -
  output logic [1:0]              raw_compare
);
  logic float_q = 1'b0;  // stands in for an unpowered, floating output

  // free toggle so a stale level never passes for a real answer
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  // powered: report the comparison; unpowered: float, inputs cut off
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      raw_compare[i] <= analog_ctrl[i].power_on ? vp_above[i] : float_q;
    end
  end
endmodule : cmp_partner

// [comparator_control_logic_chk.sv]
`timescale 1ns/1ps

// watches only the block's ports
module comparator_control_logic_chk
  import cmp_pkg::*;
#(
  parameter int n_cmp      = 2,
  parameter int port_width = 8,
  parameter int instr_div  = 4
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic [n_cmp-1:0]      raw_compare,
  input wire analog_ctrl_t [n_cmp-1:0] analog_ctrl,
  input wire logic                  timer_clk_in,
  input wire tclk_src_t             timer_clk_src,
  input wire logic [n_cmp-1:0]      timer_gate_result,
  input wire logic [n_cmp-1:0]      result_pin,
  input wire logic                  waveform_shutdown,
  input wire logic                  sleep_req,
  input wire logic                  wake_request,
  input wire logic [port_width-1:0] port_pins
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_upper_data_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_held: assert property (psel && penable && pready |=> $stable(prdata))
    else $error("read data changed after access");
  a_mirror_clean: assert property (psel && !penable && !pwrite && paddr == mirror_off |=> prdata[7:2] == 6'h0)
    else $error("mirror upper bits not zero");
  a_speed_held_one: assert property (analog_ctrl[0].speed_power_select && analog_ctrl[1].speed_power_select)
    else $error("speed select left normal power");
  a_pos_single_route: assert property ($onehot0(analog_ctrl[0].pos) && $onehot0(analog_ctrl[1].pos))
    else $error("two positive routes at once");
  a_neg_single_route: assert property ($onehot0(analog_ctrl[0].neg) && $onehot0(analog_ctrl[1].neg))
    else $error("two negative routes at once");
  a_off_isolated: assert property (!analog_ctrl[0].power_on |-> analog_ctrl[0].pos == 4'h0 && analog_ctrl[0].neg == 6'h0)
    else $error("input routed while comparator off");
  a_pin_matches_gate: assert property (result_pin == timer_gate_result)
    else $error("pin and timer result differ");

  c_write: cover property (psel && penable && pready && pwrite);
  c_read: cover property (psel && penable && pready && !pwrite);
  c_shutdown: cover property ($rose(waveform_shutdown));
  c_wake: cover property ($rose(wake_request));
endmodule : comparator_control_logic_chk

bind comparator_control_logic comparator_control_logic_chk #(
  .n_cmp(n_cmp), .port_width(port_width), .instr_div(instr_div)
) comparator_control_logic_chk_i (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .raw_compare(raw_compare),
  .analog_ctrl(analog_ctrl), .timer_clk_in(timer_clk_in), .timer_clk_src(timer_clk_src),
  .timer_gate_result(timer_gate_result), .result_pin(result_pin), .waveform_shutdown(waveform_shutdown),
  .sleep_req(sleep_req), .wake_request(wake_request), .port_pins(port_pins)
);

// [comparator_control_logic_test.sv]
`timescale 1ns/1ps

module comparator_control_logic_test
  import cmp_pkg::*;
;
  logic               sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr, port_pins;
  logic [31:0]        pwdata, prdata;
  logic [1:0]         raw_compare, vp_above, timer_gate_result, result_pin;
  analog_ctrl_t [1:0] analog_ctrl;
  logic               timer_clk_in, waveform_shutdown, sleep_req, wake_request;
  tclk_src_t          timer_clk_src;
  int                 n_mismatch = 0;       // failed comparisons
  int                 samples_checked = 0;  // all comparisons

  comparator_control_logic comparator_control_logic_i (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .raw_compare(raw_compare),
    .analog_ctrl(analog_ctrl), .timer_clk_in(timer_clk_in), .timer_clk_src(timer_clk_src),
    .timer_gate_result(timer_gate_result), .result_pin(result_pin), .waveform_shutdown(waveform_shutdown),
    .sleep_req(sleep_req), .wake_request(wake_request), .port_pins(port_pins));
  cmp_partner cmp_partner_i (.sys_clk(sys_clk), .analog_ctrl(analog_ctrl), .vp_above(vp_above),
    .raw_compare(raw_compare));

  // wake_request stands only one cycle, so catch it here
  logic wake_seen;
  always @(posedge sys_clk) begin
    if (rst) begin
      wake_seen <= 1'b0;
    end else if (wake_request === 1'b1) begin
      wake_seen <= 1'b1;
    end
  end

  // 8 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task results;
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; trailing idle edge keeps back-to-back calls legal
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 8'h00, rd, er);
    chk(rd, exp);
  endtask : rchk

  // covers sync flops, instruction tick and flag update
  task settle;
    repeat (12) @(posedge sys_clk);
  endtask : settle

  function automatic logic [3:0] pos_exp(input logic [2:0] c);
    case (c)
      3'h7: pos_exp = 4'h8;
      3'h6: pos_exp = 4'h4;
      3'h5: pos_exp = 4'h2;
      3'h0: pos_exp = 4'h1;
      default: pos_exp = 4'h0;
    endcase
  endfunction : pos_exp

  function automatic logic [5:0] neg_exp(input logic [2:0] c);
    case (c)
      3'h7: neg_exp = 6'h20;
      3'h6: neg_exp = 6'h10;
      3'h5, 3'h4: neg_exp = 6'h00;
      default: neg_exp = 6'h01 << c;
    endcase
  endfunction : neg_exp

  // hang guard, far above the sequence length
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    {psel, penable, pwrite, sleep_req} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_pins = 8'hff;
    vp_above = 2'h0;
    timer_clk_in = 1'b1;
    timer_clk_src = tclk_ext;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk(ctrl_a1_off, 32'h04);
    rchk(insel1_off, 32'h00);
    rchk(mirror_off, 32'h00);
    wr(ctrl_a1_off, 8'h2b);
    rchk(ctrl_a1_off, 32'h07);
    apb(1'b0, 8'h40, 8'h00, rd, er);
    chk({rd[31:1], er}, 32'h1);
    // routing table, every code on both selects
    wr(ctrl_a1_off, 8'h86);
    chk({30'h0, analog_ctrl[0].power_on, analog_ctrl[0].hysteresis_enable}, 32'h3);
    for (int i = 0; i < 8; i++) begin
      wr(insel1_off, {2'b00, i[2:0], i[2:0]});
      chk({22'h0, analog_ctrl[0].pos, analog_ctrl[0].neg}, {22'h0, pos_exp(i[2:0]), neg_exp(i[2:0])});
    end
    wr(ctrl_a1_off, 8'h04);
    chk({20'h0, analog_ctrl[0].pos, analog_ctrl[0].neg, analog_ctrl[0].power_on, analog_ctrl[0].hysteresis_enable}, 32'h0);
    // edge flags, rise only
    wr(insel1_off, 8'h80);
    wr(ctrl_a1_off, 8'h84);
    settle();
    wr(status_off, 8'h03);
    rchk(status_off, 32'h0);
    vp_above <= 2'h1;
    settle();
    rchk(mirror_off, 32'h1);
    rchk(ctrl_a1_off, 32'hc4);
    rchk(status_off, 32'h1);
    wr(status_off, 8'h01);
    rchk(status_off, 32'h0);
    wr(ctrl_a1_off, 8'h94);
    settle();
    rchk(mirror_off, 32'h0);
    rchk(status_off, 32'h0);
    // fall only
    wr(insel1_off, 8'h40);
    wr(ctrl_a1_off, 8'h84);
    settle();
    rchk(status_off, 32'h0);
    wr(ctrl_a1_off, 8'h94);
    settle();
    rchk(status_off, 32'h1);
    // disabled comparator, polarity toggle still flags
    wr(insel1_off, 8'h80);
    wr(ctrl_a1_off, 8'h04);
    settle();
    wr(status_off, 8'h03);
    wr(ctrl_a1_off, 8'h14);
    wr(ctrl_a2_off, 8'h14);
    settle();
    rchk(status_off, 32'h1);
    rchk(mirror_off, 32'h3);
    // shutdown link, both results high
    wr(irqen_off, 8'h04);
    chk({31'h0, waveform_shutdown}, 32'h1);
    wr(irqen_off, 8'h00);
    chk({31'h0, waveform_shutdown}, 32'h0);
    // sleep: no wake until the event is enabled
    wr(irqen_off, 8'h10);
    settle();
    chk({31'h0, wake_seen}, 32'h0);
    wr(irqen_off, 8'h11);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, wake_seen}, 32'h1);
    rchk(irqen_off, 32'h01);
    // async then sync output path
    wr(ctrl_a1_off, 8'h84);
    settle();
    chk({31'h0, timer_gate_result[0]}, 32'h1);
    wr(ctrl_a1_off, 8'h85);
    timer_clk_in <= 1'b0;
    settle();
    timer_clk_in <= 1'b1;
    vp_above <= 2'h0;
    settle();
    chk({31'h0, result_pin[0]}, 32'h1);
    timer_clk_in <= 1'b0;
    settle();
    chk({31'h0, result_pin[0]}, 32'h0);
    // system-clocked timer: sync path frozen while asleep
    wr(irqen_off, 8'h10);
    timer_clk_src <= tclk_sys;
    vp_above <= 2'h1;
    settle();
    chk({31'h0, result_pin[0]}, 32'h0);
    rchk(mirror_off, 32'h3);
    wr(irqen_off, 8'h01);
    settle();
    chk({31'h0, result_pin[0]}, 32'h1);
    // analogue pins read zero on the port
    wr(ansel_off, 8'h0f);
    settle();
    rchk(port_off, 32'hf0);
    results();
  end
endmodule : comparator_control_logic_test
